/* core/tacp_pkg.sv */
// Constants and types shared by the timer A control and prescaler block
package tacp_pkg;

	// ****************************************************************
	// Register indices and byte addresses
	// ****************************************************************
	localparam logic [7:0] IDX_CONTROL  = 8'hE2;
	localparam logic [7:0] IDX_PRESCALE = 8'hE3;
	localparam logic [7:0] IDX_DATA     = 8'hE4;
	localparam logic [7:0] IDX_COUNT    = 8'hE5;
	localparam logic [7:0] IDX_INT_STAT = 8'hE6;
	localparam logic [7:0] IDX_INT_MASK = 8'hE7;
	localparam logic [9:0] ADDR_CONTROL  = {IDX_CONTROL, 2'h0};
	localparam logic [9:0] ADDR_PRESCALE = {IDX_PRESCALE, 2'h0};
	localparam logic [9:0] ADDR_DATA     = {IDX_DATA, 2'h0};
	localparam logic [9:0] ADDR_COUNT    = {IDX_COUNT, 2'h0};
	localparam logic [9:0] ADDR_INT_STAT = {IDX_INT_STAT, 2'h0};
	localparam logic [9:0] ADDR_INT_MASK = {IDX_INT_MASK, 2'h0};

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTL_MODE_LO    = 6;
	localparam int CTL_CLEAR      = 5;
	localparam int CTL_RUN        = 4;
	localparam int CTL_EN_MATCH   = 3;
	localparam int CTL_EN_OVF     = 2;
	localparam int CTL_PEND_MATCH = 1;
	localparam int CTL_PEND_OVF   = 0;
	localparam int PS_SRC         = 7;
	localparam int IST_MATCH      = 0;
	localparam int IST_OVF        = 1;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [7:0]  CONTROL_RST  = 8'h00;
	localparam logic [7:0]  PRESCALE_RST = 8'h00;
	localparam logic [7:0]  DATA_RST     = 8'hFF;
	localparam logic [1:0]  MASK_RST     = 2'h0;
	localparam logic [3:0]  PS_MAX       = 4'hC;
	localparam logic [11:0] PCNT_RST     = 12'h000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'h0,
		MODE_CAP_RISE = 2'h1,
		MODE_CAP_FALL = 2'h2,
		MODE_PWM      = 2'h3
	} tacp_mode_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK  = 2'h2
	} tacp_bus_t;

endpackage : tacp_pkg

/* core/tacp_prescaler.sv */
// Power-of-two prescaler for the timer A clock
`timescale 1ns/1ps
module tacp_prescaler (
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	// Tick carrier
	tacp_tick_if.presc  tk
);

	typedef struct packed {
		logic [11:0] cnt;
		logic        tick;
	} tacp_presc_t;

	tacp_presc_t        st;
	tacp_presc_t        next_st;
	logic        [3:0]  ps_eff;
	logic        [12:0] limit;

	// ****************************************************************
	// Divide the source by two to the prescale value
	// ****************************************************************
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		// Invalid settings are held at the largest divider
		ps_eff = (tk.ps_value > tacp_pkg::PS_MAX) ? tacp_pkg::PS_MAX : tk.ps_value;
		limit = (13'h0001 << ps_eff) - 13'h0001;
		if (tk.clear)
			next_st.cnt = tacp_pkg::PCNT_RST;
		else if (tk.src_tick)
		begin
			if ({1'b0, st.cnt} >= limit)
			begin
				next_st.cnt = tacp_pkg::PCNT_RST;
				next_st.tick = 1'b1;
			end
			else
				next_st.cnt = st.cnt + 12'h001;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st <= '{cnt: tacp_pkg::PCNT_RST, tick: 1'b0};
		else
			st <= next_st;
	end

	assign tk.tick = st.tick;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_divide_by_one: assert property (tk.src_tick && !tk.clear && tk.ps_value == 4'h0 |=> tk.tick)
		else $error("prescaler of one did not tick");
	a_source_gates_tick: assert property (!tk.src_tick |=> !tk.tick)
		else $error("tick without a source tick");
	a_tick_spacing: assert property (tk.tick && tk.ps_value == 4'h3 |->
		##1 (!tk.tick || tk.ps_value != 4'h3) [*7])
		else $error("divide by eight ticked too soon");

endmodule : tacp_prescaler

/* core/tacp_tick_if.sv */
// Carrier between the timer control and its prescaler
`timescale 1ns/1ps
interface tacp_tick_if;
	logic       src_tick;
	logic [3:0] ps_value;
	logic       clear;
	logic       tick;

	modport ctrl  (output src_tick, output ps_value, output clear, input tick);
	modport presc (input src_tick, input ps_value, input clear, output tick);
endinterface : tacp_tick_if

/* core/tacp_timer_a.sv */
// Timer A control, prescaler, interrupt flags and register slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tacp_timer_a (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Timer pins
	input  wire logic        timer_a_ext_clock_pin,
	input  wire logic        timer_a_capture_pin,
	output logic             timer_a_output_pin,
	// Interrupt
	output logic             timer_irq
);

	typedef struct packed {
		tacp_pkg::tacp_mode_t mode;
		logic                 run;
		logic                 en_match;
		logic                 en_ovf;
		logic                 pend_match;
		logic                 pend_ovf;
		logic                 ext_sel;
		logic [3:0]           ps;
		logic [7:0]           data;
		logic [7:0]           cnt;
		logic [7:0]           capture;
		logic                 out_pin;
		logic [1:0]           ist;
		logic [1:0]           mask;
		logic                 irq;
		logic                 ext_prev;
		logic                 cap_prev;
		logic                 clr_pulse;
		tacp_pkg::tacp_bus_t  bus;
		logic [31:0]          rdata;
		logic                 waitreq;
	} tacp_state_t;

	tacp_state_t st;
	tacp_state_t next_st;
	tacp_tick_if tk ();

	logic        wr_en;
	logic        wr_ctl;
	logic        clr_req;
	logic        count_en;
	logic        cap_edge;
	logic        ev_match;
	logic        ev_ovf;
	logic [7:0]  ctl_rd;
	logic [7:0]  ps_rd;
	logic [31:0] rd_mux;

	// ****************************************************************
	// Prescaler
	// ****************************************************************
	assign tk.src_tick = st.ext_sel ? (timer_a_ext_clock_pin && !st.ext_prev) : 1'b1;
	assign tk.ps_value = st.ps;
	assign tk.clear    = st.clr_pulse;

	tacp_prescaler u_presc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tk       (tk.presc)
	);

	// ****************************************************************
	// Register read view
	// ****************************************************************
	always_comb
	begin
		ctl_rd = {st.mode, 1'b0, st.run, st.en_match, st.en_ovf, st.pend_match, st.pend_ovf};
		ps_rd = {st.ext_sel, 3'h0, st.ps};
		case (avs_address)
			tacp_pkg::ADDR_CONTROL:  rd_mux = {24'h000000, ctl_rd};
			tacp_pkg::ADDR_PRESCALE: rd_mux = {24'h000000, ps_rd};
			tacp_pkg::ADDR_DATA:     rd_mux = {24'h000000, st.data};
			tacp_pkg::ADDR_COUNT:    rd_mux = {15'h0000, st.out_pin, st.capture, st.cnt};
			tacp_pkg::ADDR_INT_STAT: rd_mux = {30'h00000000, st.ist};
			tacp_pkg::ADDR_INT_MASK: rd_mux = {30'h00000000, st.mask};
			default:                 rd_mux = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// Timer events
	// ****************************************************************
	always_comb
	begin
		wr_en = (st.bus == tacp_pkg::BUS_ACK) && avs_write && avs_byteenable[0];
		wr_ctl = wr_en && (avs_address == tacp_pkg::ADDR_CONTROL);
		clr_req = wr_ctl && avs_writedata[tacp_pkg::CTL_CLEAR];
		count_en = st.run && tk.tick;
		cap_edge = 1'b0;
		ev_match = 1'b0;
		ev_ovf = 1'b0;
		case (st.mode)
			tacp_pkg::MODE_INTERVAL:
			begin
				ev_match = count_en && (st.cnt == st.data);
			end
			tacp_pkg::MODE_CAP_RISE:
			begin
				cap_edge = st.run && timer_a_capture_pin && !st.cap_prev;
				ev_match = cap_edge;
				ev_ovf = count_en && (st.cnt == 8'hFF);
			end
			tacp_pkg::MODE_CAP_FALL:
			begin
				cap_edge = st.run && !timer_a_capture_pin && st.cap_prev;
				ev_match = cap_edge;
				ev_ovf = count_en && (st.cnt == 8'hFF);
			end
			tacp_pkg::MODE_PWM:
			begin
				ev_match = count_en && (st.cnt == st.data);
				ev_ovf = count_en && (st.cnt == 8'hFF);
			end
			default:
			begin
				ev_match = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		next_st = st;
		next_st.ext_prev = timer_a_ext_clock_pin;
		next_st.cap_prev = timer_a_capture_pin;
		next_st.clr_pulse = clr_req;

		// Bus handshake: one wait cycle, then the ending edge
		case (st.bus)
			tacp_pkg::BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					next_st.bus = tacp_pkg::BUS_ACK;
					next_st.waitreq = 1'b0;
					next_st.rdata = avs_read ? rd_mux : 32'h00000000;
				end
			end
			tacp_pkg::BUS_ACK:
			begin
				next_st.bus = tacp_pkg::BUS_IDLE;
				next_st.waitreq = 1'b1;
			end
			default:
			begin
				next_st.bus = tacp_pkg::BUS_IDLE;
				next_st.waitreq = 1'b1;
			end
		endcase

		// Register writes
		if (wr_en)
		begin
			case (avs_address)
				tacp_pkg::ADDR_CONTROL:
				begin
					next_st.mode = tacp_pkg::tacp_mode_t'(avs_writedata[7:6]);
					next_st.run = avs_writedata[tacp_pkg::CTL_RUN];
					next_st.en_match = avs_writedata[tacp_pkg::CTL_EN_MATCH];
					next_st.en_ovf = avs_writedata[tacp_pkg::CTL_EN_OVF];
					if (!avs_writedata[tacp_pkg::CTL_PEND_MATCH])
						next_st.pend_match = 1'b0;
					if (!avs_writedata[tacp_pkg::CTL_PEND_OVF])
						next_st.pend_ovf = 1'b0;
				end
				tacp_pkg::ADDR_PRESCALE:
				begin
					next_st.ext_sel = avs_writedata[tacp_pkg::PS_SRC];
					next_st.ps = avs_writedata[3:0];
				end
				tacp_pkg::ADDR_DATA:
				begin
					next_st.data = avs_writedata[7:0];
				end
				tacp_pkg::ADDR_INT_STAT:
				begin
					next_st.ist = st.ist & ~avs_writedata[1:0];
				end
				tacp_pkg::ADDR_INT_MASK:
				begin
					next_st.mask = avs_writedata[1:0];
				end
				default:
				begin
					next_st.data = st.data;
				end
			endcase
		end

		// Counter and output pin
		if (clr_req)
			next_st.cnt = 8'h00;
		else if (count_en)
		begin
			if (st.mode == tacp_pkg::MODE_INTERVAL && ev_match)
				next_st.cnt = 8'h00;
			else
				next_st.cnt = st.cnt + 8'h01;
		end
		if (st.mode == tacp_pkg::MODE_INTERVAL && ev_match)
			next_st.out_pin = !st.out_pin;
		else if (st.mode == tacp_pkg::MODE_PWM)
			next_st.out_pin = (next_st.cnt < st.data);
		if (cap_edge)
			next_st.capture = st.cnt;

		// Hardware set wins over a software clear
		if (ev_match)
		begin
			next_st.pend_match = 1'b1;
			next_st.ist[tacp_pkg::IST_MATCH] = 1'b1;
		end
		if (ev_ovf)
		begin
			next_st.pend_ovf = 1'b1;
			next_st.ist[tacp_pkg::IST_OVF] = 1'b1;
		end

		next_st.irq = (next_st.pend_match && next_st.en_match)
			|| (next_st.pend_ovf && next_st.en_ovf)
			|| (|(next_st.ist & next_st.mask));
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.mode <= tacp_pkg::tacp_mode_t'(tacp_pkg::CONTROL_RST[7:6]);
			st.run <= tacp_pkg::CONTROL_RST[tacp_pkg::CTL_RUN];
			st.ext_sel <= tacp_pkg::PRESCALE_RST[tacp_pkg::PS_SRC];
			st.ps <= tacp_pkg::PRESCALE_RST[3:0];
			st.data <= tacp_pkg::DATA_RST;
			st.mask <= tacp_pkg::MASK_RST;
			st.bus <= tacp_pkg::BUS_IDLE;
			st.waitreq <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign avs_readdata       = st.rdata;
	assign avs_waitrequest    = st.waitreq;
	assign timer_a_output_pin = st.out_pin;
	assign timer_irq          = st.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_clear_zero_count: assert property (clr_req |=> st.cnt == 8'h00)
		else $error("counter clear did not zero the counter");
	a_clear_reads_zero: assert property (
		st.bus == tacp_pkg::BUS_IDLE && avs_read && avs_address == tacp_pkg::ADDR_CONTROL
		|=> !avs_waitrequest && !avs_readdata[tacp_pkg::CTL_CLEAR])
		else $error("counter clear bit read back as one");
	a_stop_holds_count: assert property (!st.run && !clr_req |=> $stable(st.cnt))
		else $error("stopped counter moved");
	a_run_counts_up: assert property (
		count_en && !clr_req && st.mode == tacp_pkg::MODE_CAP_RISE
		|=> st.cnt == 8'($past(st.cnt) + 8'h01))
		else $error("running counter did not step");
	a_capture_latch: assert property (cap_edge |=> st.capture == $past(st.cnt) && st.pend_match)
		else $error("capture edge lost");
	a_pend_write_zero: assert property (
		wr_ctl && !avs_writedata[tacp_pkg::CTL_PEND_OVF] && !ev_ovf |=> !st.pend_ovf)
		else $error("overflow flag not cleared by a zero");
	a_pend_write_one: assert property (
		wr_ctl && avs_writedata[tacp_pkg::CTL_PEND_MATCH] && st.pend_match |=> st.pend_match)
		else $error("match flag lost on a written one");
	a_irq_request: assert property (
		(st.pend_match && st.en_match) || (st.pend_ovf && st.en_ovf) |-> timer_irq)
		else $error("interrupt request missing");
	a_enable_blocks: assert property (
		!st.en_match && !st.en_ovf && ((st.ist & st.mask) == 2'h0) |-> !timer_irq)
		else $error("interrupt through a closed enable");
	a_ext_source: assert property (
		st.ext_sel && !(timer_a_ext_clock_pin && !$past(timer_a_ext_clock_pin))
		|-> !tk.src_tick)
		else $error("internal clock used with external source");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");

endmodule : tacp_timer_a

/* testbench/tacp_pin_model.sv */
// Model of the external timer clock and capture pins
`timescale 1ns/1ps
module tacp_pin_model (
	// Clock
	input  wire logic core_clk,
	// Pins
	output logic      timer_a_ext_clock_pin,
	output logic      timer_a_capture_pin
);
	initial
	begin
		timer_a_ext_clock_pin = 1'b0;
		timer_a_capture_pin   = 1'b0;
	end

	// Clock pin idles low outside a burst
	task automatic send_edges(input int n, input int gap);
		repeat (n)
		begin
			@(posedge core_clk) timer_a_ext_clock_pin <= 1'b1;
			repeat (gap) @(posedge core_clk);
			@(posedge core_clk) timer_a_ext_clock_pin <= 1'b0;
			repeat (gap) @(posedge core_clk);
		end
	endtask : send_edges

	task automatic set_cap(input logic lvl);
		@(posedge core_clk) timer_a_capture_pin <= lvl;
	endtask : set_cap
endmodule : tacp_pin_model

/* testbench/tacp_timer_a_bench.sv */
// Self-checking bench for the timer A control and prescaler
`timescale 1ns/1ps
module tacp_timer_a_bench;
	// ****************
	// Signals
	// ****************
	localparam logic [9:0] A_CTL = tacp_pkg::ADDR_CONTROL;
	localparam logic [9:0] A_PS  = tacp_pkg::ADDR_PRESCALE;
	localparam logic [9:0] A_DAT = tacp_pkg::ADDR_DATA;
	localparam logic [9:0] A_CNT = tacp_pkg::ADDR_COUNT;
	localparam logic [9:0] A_ST  = tacp_pkg::ADDR_INT_STAT;
	localparam logic [9:0] A_MK  = tacp_pkg::ADDR_INT_MASK;
	logic        core_clk;
	logic        rst_n;
	logic [9:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ext_pin;
	logic        cap_pin;
	logic        timer_irq;
	logic        out_pin;
	logic [3:0]  be;
	logic        wq_s;
	logic [7:0]  irq_s;
	logic [7:0]  pin_s;
	logic [7:0]  rd_s;
	logic [7:0]  rdv;
	logic [7:0]  c0;
	int          fail_count = 0;
	int          total_checks = 0;
	int          seed;
	int          used;
	int          m;
	int          p;
	int          k;

	tacp_timer_a u_tacp_timer_a (
		.core_clk              (core_clk),
		.rst_n                 (rst_n),
		.avs_address           (avs_address),
		.avs_read              (avs_read),
		.avs_write             (avs_write),
		.avs_writedata         (avs_writedata),
		.avs_byteenable        (be),
		.avs_readdata          (avs_readdata),
		.avs_waitrequest       (avs_waitrequest),
		.timer_a_ext_clock_pin (ext_pin),
		.timer_a_capture_pin   (cap_pin),
		.timer_a_output_pin    (out_pin),
		.timer_irq             (timer_irq)
	);

	tacp_pin_model u_tacp_pin_model (
		.core_clk              (core_clk),
		.timer_a_ext_clock_pin (ext_pin),
		.timer_a_capture_pin   (cap_pin)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Values as they stand just before each rising edge
	always @(negedge core_clk)
	begin
		wq_s  <= avs_waitrequest;
		rd_s  <= avs_readdata[7:0];
		irq_s <= {7'h00, timer_irq};
		pin_s <= {7'h00, out_pin};
	end

	// ****************
	// Tasks
	// ****************
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input int wr, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= (wr != 0);
		avs_read      <= (wr == 0);
		for (n = 1; n <= 20; n++)
		begin
			@(posedge core_clk);
			if (wq_s === 1'b0)
				break;
		end
		rdv = rd_s;
		used = n;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n > 20)
		begin
			fail_count++;
			tally_and_finish();
		end
	endtask : bus

	// ****************
	// Sequence
	// ****************
	initial
	begin
		seed = 19751;
		rst_n = 1'b0;
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		be = 4'hF;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(0, A_CTL, 8'h00); check("control reset", rdv, 8'h00);
		bus(0, A_PS, 8'h00); check("prescale reset", rdv, 8'h00);
		bus(0, 10'h004, 8'h00); check("unmapped", rdv, 8'h00);
		check("irq reset", irq_s, 8'h00);
		check("pin reset", pin_s, 8'h00);
		be <= 4'h0;
		bus(1, A_CTL, 8'hFF);
		be <= 4'hF;
		bus(0, A_CTL, 8'h00); check("lane off write", rdv, 8'h00);
		$display("test reset done");
		for (m = 0; m < 4; m++)
		begin
			k = (m << 6) | 8'h20 | ($random(seed) & 8'h0C);
			bus(1, A_CTL, 8'(k));
			bus(0, A_CTL, 8'h00); check("mode readback", rdv, 8'(k & 8'hDF));
		end
		$display("test modes done");
		for (int i = 0; i < 3; i++)
		begin
			p = (i == 0) ? 0 : (i == 1) ? 3 : 12;
			bus(1, A_PS, 8'(p | 8'h70));
			bus(0, A_PS, 8'h00); check("prescale readback", rdv, 8'(p));
			bus(1, A_CTL, 8'hD0);
			bus(0, A_CNT, 8'h00);
			c0 = rdv;
			repeat ((8 << p) - used - 1) @(posedge core_clk);
			bus(0, A_CNT, 8'h00); check("count step", 8'(rdv - c0), 8'h08);
		end
		$display("test prescale done");
		bus(1, A_PS, 8'h00);
		bus(1, A_CTL, 8'hE0);
		bus(0, A_CNT, 8'h00); check("cleared", rdv, 8'h00);
		repeat (20) @(posedge core_clk);
		bus(0, A_CNT, 8'h00); check("stopped", rdv, 8'h00);
		bus(1, A_PS, 8'h80);
		bus(1, A_CTL, 8'hD0);
		repeat (20) @(posedge core_clk);
		bus(0, A_CNT, 8'h00); check("no pin edges", rdv, 8'h00);
		k = 3 + ($random(seed) & 3);
		u_tacp_pin_model.send_edges(k, $random(seed) & 3);
		repeat (6) @(posedge core_clk);
		bus(0, A_CNT, 8'h00); check("pin edges", rdv, 8'(k));
		$display("test clock source done");
		bus(1, A_PS, 8'h00);
		bus(1, A_CTL, 8'hF0);
		repeat (300) @(posedge core_clk);
		for (m = 0; m < 4; m++)
		begin
			bus(1, A_CTL, 8'(8'hC3 | (m << 2)));
			bus(0, A_CTL, 8'h00); check("pending kept", rdv, 8'(8'hC3 | (m << 2)));
			check("irq enable", irq_s, 8'(m != 0));
		end
		bus(1, A_CTL, 8'hCE);
		bus(0, A_CTL, 8'h00); check("ovf cleared", rdv, 8'hCE);
		check("irq match", irq_s, 8'h01);
		bus(1, A_CTL, 8'hCC);
		bus(0, A_CTL, 8'h00); check("irq none", irq_s, 8'h00);
		bus(0, A_ST, 8'h00); check("status", rdv, 8'h03);
		bus(1, A_MK, 8'h02);
		bus(0, A_MK, 8'h00); check("masked irq", irq_s, 8'h01);
		bus(1, A_ST, 8'h02);
		bus(0, A_ST, 8'h00); check("status w1c", rdv, 8'h01);
		check("irq after w1c", irq_s, 8'h00);
		$display("test interrupts done");
		for (m = 1; m < 3; m++)
		begin
			bus(1, A_CTL, 8'((m << 6) | 8'h30));
			u_tacp_pin_model.set_cap(1'b1);
			repeat (4) @(posedge core_clk);
			bus(0, A_CTL, 8'h00); check("capture rise", rdv, 8'((m << 6) | ((m == 1) ? 8'h12 : 8'h10)));
			u_tacp_pin_model.set_cap(1'b0);
			repeat (4) @(posedge core_clk);
			bus(0, A_CTL, 8'h00); check("capture fall", rdv, 8'((m << 6) | 8'h12));
		end
		$display("test capture done");
		k = $random(seed) & 8'hFF;
		bus(1, A_DAT, 8'(k));
		bus(1, A_CTL, 8'hF0);
		repeat (40 + ($random(seed) & 8'h7F)) @(posedge core_clk);
		bus(1, A_CTL, 8'hC0);
		bus(0, A_CNT, 8'h00); check("pwm level", pin_s, 8'(rdv < 8'(k)));
		$display("test output pin done");
		tally_and_finish();
	end
endmodule : tacp_timer_a_bench
